// ---- drc_pkg.sv ----
// Package for the dual resolver converter port: offsets, fields, ID bytes, timing
// Assumes the IP-style mezzanine bus with byte addresses on a 16-bit data path
package drc_pkg;
  localparam logic [5:0] ADDR_CH1_DATA = 6'h00;
  localparam logic [5:0] ADDR_CH1_STAT = 6'h03;
  localparam logic [5:0] ADDR_CH1_CTRL = 6'h05;
  localparam logic [5:0] ADDR_CH2_DATA = 6'h08;
  localparam logic [5:0] ADDR_CH2_STAT = 6'h0B;
  localparam logic [5:0] ADDR_CH2_CTRL = 6'h0D;
  localparam logic [5:0] ID_LAST       = 6'h3F;
  localparam int         CTRL_RES_LSB  = 0;
  localparam int         CTRL_HOLD_BIT = 2;
  localparam int         CTRL_BOTH_BIT = 3;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h3F;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         STAT_ERR_BIT  = 0;
  localparam int         STAT_LOST_BIT = 1;
  localparam int         DATA_WAIT     = 2;
  localparam real        BUS_CLK_MHZ   = 8.0;
  localparam logic [7:0] ID_HDR_I      = 8'h49;
  localparam logic [7:0] ID_HDR_P      = 8'h50;
  localparam logic [7:0] ID_HDR_A      = 8'h41;
  localparam logic [7:0] ID_HDR_C      = 8'h43;
  localparam logic [7:0] ID_USED_BYTES = 8'h0D;
  typedef enum logic [1:0] {RES_10, RES_12, RES_14, RES_16} drc_res_t;
  typedef struct packed {
    logic       err;
    logic       signal_lost_flag;
    logic [15:0] angle;
  } drc_conv_t;
  typedef struct packed {
    logic       sel_io;
    logic       sel_id;
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } drc_req_t;
endpackage

// ---- drc_channel.sv ----
// One converter channel: effective resolution, angle masking, status latch
// Assumes converter inputs already synchronised to clk
`timescale 1ns/100ps
module drc_channel (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire drc_pkg::drc_conv_t conv,
  input  wire logic [1:0]       res_prog,
  input  wire logic             latch_now,
  input  wire logic             latch_release,
  output logic [1:0]            res_eff,
  output logic [15:0]           angle_out,
  output logic [7:0]            status_out
);
  logic       latched_reg;
  logic [1:0] stat_reg;
  logic [15:0] res_mask;
  logic [7:0] live_stat;

  // Drop one step while test error is set, holding at RES_10 when already there
  assign res_eff = (conv.err && res_prog != 2'h0) ? res_prog - 2'h1 : res_prog;
  assign res_mask = 16'hFFFF << (6'(6) - {3'h0, res_eff, 1'b0});
  assign angle_out = conv.angle & res_mask;
  assign live_stat = {6'h00, conv.signal_lost_flag, conv.err};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_reg <= 1'b0;
      stat_reg    <= 2'h0;
    end else if (ce) begin
      if (latch_now) begin
        latched_reg <= 1'b1;
        stat_reg    <= live_stat[1:0];
      end else if (latch_release) begin
        latched_reg <= 1'b0;
      end
    end
  end

  assign status_out = latched_reg ? {6'h00, stat_reg} : live_stat;
endmodule

// ---- drc_port.sv ----
// File holds the top module: bus slave, control registers, ID space
// Assumes bus strobes and converter flags arrive asynchronously on pins
`timescale 1ns/100ps
module drc_port #(
  parameter logic [7:0] ID_MFR      = 8'hA5,
  parameter logic [7:0] ID_MODEL    = 8'h5A,
  parameter logic [7:0] ID_REV      = 8'h01,
  parameter logic [7:0] ID_CHECKSUM = 8'h00,
  parameter logic [7:0] ID_OPTION   = 8'h00,
  parameter logic       HAS_OSC     = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        io_sel_n,
  input  wire logic        id_sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [5:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  conv_err,
  input  wire logic [1:0]  conv_los,
  input  wire logic [31:0] conv_angle,
  output logic [15:0]      rdata,
  output logic             rdata_oe,
  output logic             ack_n,
  output logic [1:0]       res_out,
  output logic [1:0]       res_out2,
  output logic             conv_start
);
  logic [1:0]  rst_sync_reg;
  logic        rst_i_n;
  logic [2:0]  s_io_reg, s_id_reg, s_rd_reg, s_wr_reg;
  logic        io_q, id_q, rd_q, wr_q;
  logic [5:0]  a1_reg, a2_reg;
  logic [15:0] w1_reg, w2_reg;
  // Converter pin stages and the held copies that the channels use
  logic [1:0]  e1_reg, e2_reg, e3_reg, l1_reg, l2_reg, l3_reg;
  logic [31:0] g1_reg, g2_reg, g3_reg;
  logic [1:0]  err_seen_reg, los_seen_reg;
  logic [31:0] ang_seen_reg;
  logic [1:0]  err_seen_next, los_seen_next;
  logic [31:0] ang_seen_next;
  logic [7:0]  ctrl1_reg, ctrl2_reg;
  logic        busy_reg;
  logic [1:0]  wait_reg;
  logic [15:0] rdata_next;
  logic [15:0] io_rd, id_rd;
  logic [7:0]  id_byte;
  logic        start, is_data, done_now;
  logic [15:0] ang1, ang2;
  logic [7:0]  st1, st2;
  logic [1:0]  re1, re2;
  drc_pkg::drc_conv_t cv1, cv2;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_i_n = rst_sync_reg[1];

  // Three-flop synchronisers on the bus strobes
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s_io_reg <= 3'h7;
      s_id_reg <= 3'h7;
      s_rd_reg <= 3'h7;
      s_wr_reg <= 3'h7;
    end else if (ce) begin
      s_io_reg <= {s_io_reg[1:0], io_sel_n};
      s_id_reg <= {s_id_reg[1:0], id_sel_n};
      s_rd_reg <= {s_rd_reg[1:0], rd_n};
      s_wr_reg <= {s_wr_reg[1:0], wr_n};
    end
  end

  // Address and write data, held steady by the host around the strobes
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      a1_reg <= 6'h00;
      a2_reg <= 6'h00;
      w1_reg <= 16'h0000;
      w2_reg <= 16'h0000;
    end else if (ce) begin
      a1_reg <= addr;
      a2_reg <= a1_reg;
      w1_reg <= wdata;
      w2_reg <= w1_reg;
    end
  end

  // Converter flags: three stages each
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      e1_reg       <= 2'h0;
      e2_reg       <= 2'h0;
      e3_reg       <= 2'h0;
      l1_reg       <= 2'h0;
      l2_reg       <= 2'h0;
      l3_reg       <= 2'h0;
      err_seen_reg <= 2'h0;
      los_seen_reg <= 2'h0;
    end else if (ce) begin
      e1_reg       <= conv_err;
      e2_reg       <= e1_reg;
      e3_reg       <= e2_reg;
      l1_reg       <= conv_los;
      l2_reg       <= l1_reg;
      l3_reg       <= l2_reg;
      err_seen_reg <= err_seen_next;
      los_seen_reg <= los_seen_next;
    end
  end

  // Converter angle: three stages
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      g1_reg       <= 32'h0;
      g2_reg       <= 32'h0;
      g3_reg       <= 32'h0;
      ang_seen_reg <= 32'h0;
    end else if (ce) begin
      g1_reg       <= conv_angle;
      g2_reg       <= g1_reg;
      g3_reg       <= g2_reg;
      ang_seen_reg <= ang_seen_next;
    end
  end

  // A flag bit counts once stages two and three agree, else it holds
  assign err_seen_next = (e2_reg & e3_reg) | (err_seen_reg & (e2_reg ^ e3_reg));
  assign los_seen_next = (l2_reg & l3_reg) | (los_seen_reg & (l2_reg ^ l3_reg));
  // The angle is taken whole, so a word caught mid-change is never used
  assign ang_seen_next = (g2_reg == g3_reg) ? g2_reg : ang_seen_reg;

  // Strobe counts once second and third stage agree
  assign io_q = (s_io_reg[2:1] == 2'b00);
  assign id_q = (s_id_reg[2:1] == 2'b00);
  assign rd_q = (s_rd_reg[2:1] == 2'b00);
  assign wr_q = (s_wr_reg[2:1] == 2'b00);

  assign cv1 = '{err: err_seen_reg[0], signal_lost_flag: los_seen_reg[0] & HAS_OSC, angle: ang_seen_reg[15:0]};
  assign cv2 = '{err: err_seen_reg[1], signal_lost_flag: los_seen_reg[1] & HAS_OSC, angle: ang_seen_reg[31:16]};

  assign start = !busy_reg && (io_q || id_q) && (rd_q || wr_q);
  assign is_data = io_q && rd_q && (a2_reg[5:1] == drc_pkg::ADDR_CH1_DATA[5:1] ||
                                    a2_reg[5:1] == drc_pkg::ADDR_CH2_DATA[5:1]);

  // Register hits, each qualified by the take
  wire rd_c1d = start && io_q && rd_q && a2_reg[5:1] == drc_pkg::ADDR_CH1_DATA[5:1];
  wire rd_c2d = start && io_q && rd_q && a2_reg[5:1] == drc_pkg::ADDR_CH2_DATA[5:1];
  wire rd_c1s = start && io_q && rd_q && a2_reg == drc_pkg::ADDR_CH1_STAT;
  wire rd_c2s = start && io_q && rd_q && a2_reg == drc_pkg::ADDR_CH2_STAT;
  // Joint conversion mode lives in channel 1 control only
  wire joint  = ctrl1_reg[drc_pkg::CTRL_BOTH_BIT];
  // Control writes
  wire wr_c1  = start && io_q && wr_q && a2_reg == drc_pkg::ADDR_CH1_CTRL;
  wire wr_c2  = start && io_q && wr_q && a2_reg == drc_pkg::ADDR_CH2_CTRL;

  // Joint mode latches both on ch1 data read, released by ch2 status read
  wire lat1 = joint ? rd_c1d : (ctrl1_reg[drc_pkg::CTRL_HOLD_BIT] && rd_c1d);
  wire lat2 = joint ? rd_c1d : (ctrl2_reg[drc_pkg::CTRL_HOLD_BIT] && rd_c2d);
  wire rel1 = joint ? rd_c2s : rd_c1s;
  wire rel2 = rd_c2s;

  // Two converter channels
  drc_channel u_ch1 (
    .clk           (clk),
    .rst_n         (rst_i_n),
    .ce            (ce),
    .conv          (cv1),
    .res_prog      (ctrl1_reg[1:0]),
    .latch_now     (lat1),
    .latch_release (rel1),
    .res_eff       (re1),
    .angle_out     (ang1),
    .status_out    (st1)
  );
  drc_channel u_ch2 (
    .clk           (clk),
    .rst_n         (rst_i_n),
    .ce            (ce),
    .conv          (cv2),
    .res_prog      (ctrl2_reg[1:0]),
    .latch_now     (lat2),
    .latch_release (rel2),
    .res_eff       (re2),
    .angle_out     (ang2),
    .status_out    (st2)
  );

  // I/O space decode, byte on low lane
  assign io_rd = (a2_reg[5:1] == drc_pkg::ADDR_CH1_DATA[5:1]) ? ang1 :
                 (a2_reg[5:1] == drc_pkg::ADDR_CH2_DATA[5:1]) ? ang2 :
                 (a2_reg == drc_pkg::ADDR_CH1_STAT) ? {8'h00, st1} :
                 (a2_reg == drc_pkg::ADDR_CH2_STAT) ? {8'h00, st2} :
                 (a2_reg == drc_pkg::ADDR_CH1_CTRL) ? {8'h00, ctrl1_reg} :
                 (a2_reg == drc_pkg::ADDR_CH2_CTRL) ? {8'h00, ctrl2_reg} :
                 16'h0000;

  // ID space at odd byte addresses
  always_comb begin
    unique case (a2_reg)
      6'h01:   id_byte = drc_pkg::ID_HDR_I;
      6'h03:   id_byte = drc_pkg::ID_HDR_P;
      6'h05:   id_byte = drc_pkg::ID_HDR_A;
      6'h07:   id_byte = drc_pkg::ID_HDR_C;
      6'h09:   id_byte = ID_MFR;
      6'h0B:   id_byte = ID_MODEL;
      6'h0D:   id_byte = ID_REV;
      6'h15:   id_byte = drc_pkg::ID_USED_BYTES;
      6'h17:   id_byte = ID_CHECKSUM;
      6'h19:   id_byte = ID_OPTION;
      default: id_byte = 8'h00;
    endcase
  end
  assign id_rd = {8'h00, id_byte};
  assign rdata_next = id_q ? id_rd : io_rd;

  // Control registers
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ctrl1_reg <= drc_pkg::CTRL_RESET;
      ctrl2_reg <= drc_pkg::CTRL_RESET;
    end else if (ce) begin
      if (wr_c1) ctrl1_reg <= w2_reg[7:0] & drc_pkg::CTRL_WR_MASK;
      if (wr_c2) ctrl2_reg <= w2_reg[7:0] & drc_pkg::CTRL_WR_MASK;
    end
  end

  // Cycle end: no waits left and the select has gone away
  assign done_now = busy_reg && wait_reg == 2'h0 && !(io_q || id_q);

  // Effective resolution to the converters, start pulse on data reads
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      res_out    <= 2'h0;
      res_out2   <= 2'h0;
      conv_start <= 1'b0;
    end else if (ce) begin
      res_out    <= re1;
      res_out2   <= re2;
      conv_start <= rd_c1d || rd_c2d;
    end
  end

  // Read data captured at the take, driven until the cycle ends
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rdata    <= 16'h0000;
      rdata_oe <= 1'b0;
    end else if (ce) begin
      if (start) begin
        rdata    <= rdata_next;
        rdata_oe <= rd_q;
      end else if (done_now) begin
        rdata_oe <= 1'b0;
      end
    end
  end

  // Bus cycle: acknowledge now, or after two waits for data reads
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      ack_n    <= 1'b1;
    end else if (ce) begin
      ack_n <= 1'b1;
      if (start) begin
        busy_reg <= 1'b1;
        wait_reg <= is_data ? 2'(drc_pkg::DATA_WAIT) : 2'h0;
        ack_n    <= is_data;
      end else if (busy_reg && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
        ack_n    <= wait_reg != 2'h1;
      end else if (done_now) begin
        busy_reg <= 1'b0;
      end
    end
  end
endmodule

// ---- drc_port_monitor.sv ----
// Checker for the resolver converter port, watching top-level pins only
// Assumes it is bound to every drc_port instance
`timescale 1ns/100ps
module drc_port_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        io_sel_n,
  input wire logic        id_sel_n,
  input wire logic        rd_n,
  input wire logic [5:0]  addr,
  input wire logic [1:0]  conv_err,
  input wire logic [15:0] rdata,
  input wire logic        rdata_oe,
  input wire logic        ack_n,
  input wire logic [1:0]  res_out,
  input wire logic [1:0]  res_out2,
  input wire logic        conv_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire io_rd = !ack_n && !io_sel_n && !rd_n;
  property p_ack_one; !ack_n |=> ack_n; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ctrl_fast; $fell(io_sel_n) && addr == drc_pkg::ADDR_CH1_CTRL |-> ack_n [*4] ##1 !ack_n; endproperty
  a_ctrl_fast: assert property (p_ctrl_fast) else $error("control cycle slow");
  property p_data_wait; $fell(io_sel_n) && !rd_n && addr == drc_pkg::ADDR_CH1_DATA |-> ack_n [*6] ##1 !ack_n; endproperty
  a_data_wait: assert property (p_data_wait) else $error("data read wait wrong");
  property p_stat_zero; io_rd && (addr == drc_pkg::ADDR_CH1_STAT || addr == drc_pkg::ADDR_CH2_STAT) |-> rdata[7:2] == 6'h00; endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status upper bits set");
  property p_ctrl_top; io_rd && (addr == drc_pkg::ADDR_CH1_CTRL || addr == drc_pkg::ADDR_CH2_CTRL) |-> rdata[7:6] == 2'h0; endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control bits 7:6 set");
  property p_id_hdr; !ack_n && !id_sel_n && !rd_n && addr == 6'h01 |-> rdata[7:0] == drc_pkg::ID_HDR_I; endproperty
  a_id_hdr: assert property (p_id_hdr) else $error("ID header byte wrong");
  property p_res_drop; conv_err[0] [*8] |-> res_out != 2'h3; endproperty
  a_res_drop: assert property (p_res_drop) else $error("ch1 full resolution under error");
  property p_res_drop2; conv_err[1] [*8] |-> res_out2 != 2'h3; endproperty
  a_res_drop2: assert property (p_res_drop2) else $error("ch2 full resolution under error");
  property p_mask10; (res_out == 2'h0) [*8] ##0 (io_rd && addr == drc_pkg::ADDR_CH1_DATA) |-> rdata[5:0] == 6'h00; endproperty
  a_mask10: assert property (p_mask10) else $error("10-bit data low bits set");
  property p_start; conv_start |-> ##2 !ack_n; endproperty
  a_start: assert property (p_start) else $error("start without answer");
  property p_oe; !ack_n |-> rdata_oe == !rd_n; endproperty
  a_oe: assert property (p_oe) else $error("read drive enable wrong at acknowledge");
endmodule
bind drc_port drc_port_monitor u_mon (.clk(clk), .rst_n(rst_n), .io_sel_n(io_sel_n), .id_sel_n(id_sel_n),
  .rd_n(rd_n), .addr(addr), .conv_err(conv_err), .rdata(rdata), .rdata_oe(rdata_oe), .ack_n(ack_n),
  .res_out(res_out), .res_out2(res_out2), .conv_start(conv_start));

// ---- drc_host_model.sv ----
// Carrier bus master model driving strobes and waiting for acknowledge
// Assumes ack_n and rdata are sampled at the rising clock edge
`timescale 1ns/100ps
module drc_host_model (
  input  wire logic        clk,
  input  wire logic        ack_n,
  input  wire logic [15:0] rdata,
  output logic             io_sel_n,
  output logic             id_sel_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [5:0]       addr,
  output logic [15:0]      wdata
);
  int timeouts = 0;
  initial begin
    {io_sel_n, id_sel_n, rd_n, wr_n} = 4'hF;
    addr = 6'h00;
    wdata = 16'h0000;
  end
  task automatic xfer(input logic id, input logic wr, input logic [5:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    io_sel_n <= id;
    id_sel_n <= !id;
    rd_n <= wr;
    wr_n <= !wr;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_n !== 1'b0 && n < 20);
    if (ack_n !== 1'b0) timeouts++;
    q = rdata;
    {io_sel_n, id_sel_n, rd_n, wr_n} <= 4'hF;
    addr <= ~a;
    wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ---- tb_drc_port.sv ----
// Self-checking bench for the resolver converter port
// Assumes the host model is the only bus master
`timescale 1ns/100ps
module tb_drc_port;
  logic clk, rst_n, ce, io_sel_n, id_sel_n, rd_n, wr_n, ack_n;
  logic [5:0]  addr;
  logic [15:0] wdata, rdata, ang, dc;
  logic [1:0]  conv_err, conv_los, res_out, res_out2;
  logic [31:0] conv_angle;
  int err_total, tests_run, cyc;
  drc_port u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .io_sel_n(io_sel_n), .id_sel_n(id_sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .wdata(wdata), .conv_err(conv_err), .conv_los(conv_los), .conv_angle(conv_angle),
    .rdata(rdata), .rdata_oe(), .ack_n(ack_n), .res_out(res_out), .res_out2(res_out2), .conv_start());
  drc_host_model u_host (.clk(clk), .ack_n(ack_n), .rdata(rdata), .io_sel_n(io_sel_n), .id_sel_n(id_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  function automatic logic [15:0] mask(input logic [15:0] a, input logic [1:0] r);
    return a & (16'hFFFF << (6 - 2 * r));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic id, input logic [5:0] a, input logic [15:0] e);
    logic [15:0] q;
    u_host.xfer(id, 1'b0, a, 16'h0000, q);
    chk(q & ((!id && a[2:0] == 3'h0) ? 16'hFFFF : 16'h00FF), e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] q;
    u_host.xfer(1'b0, 1'b1, a, {8'h00, d}, q);
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask
  task automatic complete_run();
    err_total += u_host.timeouts;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {rst_n, ce, conv_err, conv_los, conv_angle, err_total, tests_run, cyc} = '0;
    ce = 1'b1;
    dc = $urandom(91762);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(0, drc_pkg::ADDR_CH1_CTRL, 16'h0000);
    rd(0, drc_pkg::ADDR_CH2_CTRL, 16'h0000);
    rd(1, 6'h01, drc_pkg::ID_HDR_I);
    rd(1, 6'h07, drc_pkg::ID_HDR_C);
    rd(1, 6'h15, drc_pkg::ID_USED_BYTES);
    rd(1, 6'h3F, 16'h0000);
    for (int c = 0; c < 2; c++)
      for (int r = 0; r < 4; r++) begin
        ang = $urandom;
        dc = $urandom;
        conv_angle[16 * c +: 16] <= ang;
        wr(c ? drc_pkg::ADDR_CH2_CTRL : drc_pkg::ADDR_CH1_CTRL, {2'h3, dc[1:0], 2'h0, r[1:0]});
        rd(0, c ? drc_pkg::ADDR_CH2_CTRL : drc_pkg::ADDR_CH1_CTRL, {dc[1:0], 2'h0, r[1:0]});
        rd(0, c ? drc_pkg::ADDR_CH2_DATA : drc_pkg::ADDR_CH1_DATA, mask(ang, r[1:0]));
      end
    conv_err <= 2'h1;
    conv_los <= 2'h3;
    settle();
    chk({14'h0, res_out}, 16'h0002);
    rd(0, drc_pkg::ADDR_CH1_DATA, mask(conv_angle[15:0], 2'h2));
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0003);
    rd(0, drc_pkg::ADDR_CH2_STAT, 16'h0002);
    conv_err <= 2'h0;
    conv_los <= 2'h0;
    settle();
    chk({14'h0, res_out}, 16'h0003);
    wr(drc_pkg::ADDR_CH1_CTRL, 8'h04);
    rd(0, drc_pkg::ADDR_CH1_DATA, mask(conv_angle[15:0], 2'h0));
    conv_err <= 2'h1;
    settle();
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0000);
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0001);
    wr(drc_pkg::ADDR_CH1_CTRL, 8'h08);
    conv_err <= 2'h0;
    settle();
    rd(0, drc_pkg::ADDR_CH1_DATA, mask(conv_angle[15:0], 2'h0));
    conv_err <= 2'h3;
    settle();
    chk({14'h0, res_out2}, 16'h0002);
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0000);
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0000);
    rd(0, drc_pkg::ADDR_CH2_STAT, 16'h0000);
    rd(0, drc_pkg::ADDR_CH1_STAT, 16'h0001);
    rd(0, drc_pkg::ADDR_CH2_STAT, 16'h0001);
    wr(6'h06, 8'hFF);
    rd(0, 6'h06, 16'h0000);
    rd(0, drc_pkg::ADDR_CH1_CTRL, 16'h0008);
    complete_run();
  end
endmodule
